//--- dpts_regs.svh
`ifndef DPTS_REGS_SVH
`define DPTS_REGS_SVH

// Token space geometry.
`define DPTS_TOKEN_COUNT     8
`define DPTS_TOKEN_IDX_W     3
`define DPTS_DATA_W          16
`define DPTS_ADDR_W          13
`define DPTS_FLAG_BIT        0

// Flag encodings on data bit 0 (active low token).
`define DPTS_FLAG_CLAIM      1'h0
`define DPTS_FLAG_RELEASE    1'h1

// Pin timing in nanoseconds and derived cycles at the 25 MHz clock.
`define DPTS_CLK_PERIOD_NS   40
`define DPTS_T_SETUP_NS      40
// The read strobe must outlast the two data synchroniser stages, or the
// flag is sampled before the device's answer has reached the second flop.
`define DPTS_T_STROBE_NS     120
`define DPTS_T_GAP_NS        40
`define DPTS_SETUP_CYC   ((`DPTS_T_SETUP_NS + `DPTS_CLK_PERIOD_NS - 1) / `DPTS_CLK_PERIOD_NS)
`define DPTS_STROBE_CYC  ((`DPTS_T_STROBE_NS + `DPTS_CLK_PERIOD_NS - 1) / `DPTS_CLK_PERIOD_NS)
`define DPTS_GAP_CYC     ((`DPTS_T_GAP_NS + `DPTS_CLK_PERIOD_NS - 1) / `DPTS_CLK_PERIOD_NS)
`define DPTS_CNT_W           4

`endif

//--- dpts_pkg.sv
package dpts_pkg;

    typedef enum logic [1:0] {
        DPTS_OP_CLAIM,
        DPTS_OP_RELEASE,
        DPTS_OP_READ,
        DPTS_OP_INIT
    } dpts_op_t;

    typedef struct packed {
        logic                     valid;
        dpts_op_t                 op;
        logic [2:0]               idx;
    } dpts_req_t;

    typedef struct packed {
        logic                     valid;
        logic                     granted;
        logic                     flag;
        logic [2:0]               idx;
    } dpts_rsp_t;

    typedef struct packed {
        logic                     token_bank_select_n;
        logic                     chip_enable_n;
        logic                     output_enable_n;
        logic                     read_write_n;
        logic [12:0]              addr;
        logic [15:0]              data_out;
        logic                     data_oe;
    } dpts_pins_t;

    typedef enum logic [1:0] {
        DPTS_PH_IDLE,
        DPTS_PH_SETUP,
        DPTS_PH_STROBE,
        DPTS_PH_GAP
    } dpts_phase_t;

    typedef struct packed {
        dpts_phase_t              phase;
        logic [3:0]               cnt;
        logic                     done;
        logic                     rd_flag;
    } dpts_cyc_state_t;

    typedef enum {
        DPTS_ST_IDLE,
        DPTS_ST_WRITE,
        DPTS_ST_READ,
        DPTS_ST_DONE
    } dpts_state_t;

    typedef struct packed {
        dpts_state_t              state;
        dpts_op_t                 op;
        logic [2:0]               idx;
        logic [3:0]               init_idx;
        logic                     cyc_go;
        logic                     cyc_write;
        logic                     cyc_wbit;
        dpts_rsp_t                rsp;
        logic                     busy;
    } dpts_ctl_state_t;

endpackage

//--- dpts_pin_cycle.sv
`timescale 1ns/1ps
`include "dpts_regs.svh"

// ****************************************************************
// One token-space access on the device pins
// ****************************************************************
// Every access ends with the select and output enable inactive, so a
// following read always opens a fresh capture in the device.
module dpts_pin_cycle (
    input  wire logic                        clk,
    input  wire logic                        resetn,
    input  wire logic                        ce,
    input  wire logic                        go,
    input  wire logic                        write,
    input  wire logic [2:0]                  idx,
    input  wire logic                        wbit,
    input  wire logic [`DPTS_DATA_W-1:0]     data_in_sync,
    output dpts_pkg::dpts_pins_t             pins,
    output logic                             done,
    output logic                             rd_flag
);
    import dpts_pkg::*;

    dpts_cyc_state_t st_reg;
    dpts_cyc_state_t st_next;
    dpts_pins_t      pins_reg;
    dpts_pins_t      pins_next;

    always_comb begin
        st_next   = st_reg;
        pins_next = pins_reg;
        st_next.done = 1'b0;
        case (st_reg.phase)
            DPTS_PH_IDLE: begin
                if (go) begin
                    // Upper address bits carry no meaning, drive them low. [R4]
                    pins_next.addr = {{(`DPTS_ADDR_W-`DPTS_TOKEN_IDX_W){1'b0}}, idx};
                    pins_next.token_bank_select_n = 1'b0;                  // [R3]
                    pins_next.chip_enable_n       = 1'b1;
                    pins_next.read_write_n        = 1'b1;
                    pins_next.output_enable_n     = 1'b1;
                    // Only bit 0 matters; copying it to all bits is harmless. [R5] [R2]
                    pins_next.data_out = {`DPTS_DATA_W{wbit}};
                    pins_next.data_oe  = write;
                    st_next.cnt   = 4'(`DPTS_SETUP_CYC);
                    st_next.phase = DPTS_PH_SETUP;
                end
            end
            DPTS_PH_SETUP: begin
                if (st_reg.cnt > 4'h1) begin
                    st_next.cnt = st_reg.cnt - 4'h1;
                end else begin
                    if (pins_reg.data_oe) begin
                        pins_next.read_write_n = 1'b0;
                    end else begin
                        pins_next.output_enable_n = 1'b0;                   // [R13]
                    end
                    st_next.cnt   = 4'(`DPTS_STROBE_CYC);
                    st_next.phase = DPTS_PH_STROBE;
                end
            end
            DPTS_PH_STROBE: begin
                if (st_reg.cnt > 4'h1) begin
                    st_next.cnt = st_reg.cnt - 4'h1;
                end else begin
                    // Flag is replicated on every bit; bit 0 is enough. [R12]
                    st_next.rd_flag = data_in_sync[`DPTS_FLAG_BIT];
                    pins_next.read_write_n        = 1'b1;
                    pins_next.output_enable_n     = 1'b1;
                    pins_next.token_bank_select_n = 1'b1;                   // [R14]
                    st_next.cnt   = 4'(`DPTS_GAP_CYC);
                    st_next.phase = DPTS_PH_GAP;
                end
            end
            DPTS_PH_GAP: begin
                pins_next.data_oe = 1'b0;
                if (st_reg.cnt > 4'h1) begin
                    st_next.cnt = st_reg.cnt - 4'h1;
                end else begin
                    st_next.done  = 1'b1;
                    st_next.phase = DPTS_PH_IDLE;
                end
            end
            default: begin
                st_next.phase = DPTS_PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg   <= '{phase: DPTS_PH_IDLE, cnt: 4'h0, done: 1'b0, rd_flag: 1'b1};
            pins_reg <= '{token_bank_select_n: 1'b1, chip_enable_n: 1'b1,
                          output_enable_n: 1'b1, read_write_n: 1'b1,
                          addr: '0, data_out: '0, data_oe: 1'b0};
        end else if (ce) begin
            st_reg   <= st_next;
            pins_reg <= pins_next;
        end
    end

    assign pins    = pins_reg;
    assign done    = st_reg.done;
    assign rd_flag = st_reg.rd_flag;
endmodule

//--- dpts_host.sv
`timescale 1ns/1ps
`include "dpts_regs.svh"

// Overview of operation
// R1 - Device holds eight token latches apart from its memory array.
// R2 - Flags active low: write zero to request, one to release.
// R3 - Token space reached with token bank select low, SRAM-style strobes.
// R4 - Only the three lowest address bits pick the token.
// R5 - Device uses only data bit 0 on token writes.
// R6 - Zero on free token: writer reads zero, other side reads one.
// R7 - Owner writing one frees token unless other side has pending request.
// R8 - Non-owner zero waits in its request latch until token freed.
// R9 - Pending request takes ownership immediately when owner releases.
// R10 - First request latch presenting zero wins until it writes one.
// R11 - Pending requester reads flag as one while other side owns.
// R12 - Token reads return the flag on every data bit.
// R13 - Read value latched while select and output enable stay active.
// R14 - Between polling reads, select or output enable must go inactive.
// R15 - Claim by write zero then read back; own only on zero.
// R16 - After failed claim, keep reading or write one to withdraw.
// R17 - Simultaneous requests: exactly one side wins, earlier first.
// R18 - Token latches are undefined after power-up.
// R19 - At start-up write one to all eight tokens.
// R20 - Flags gate no hardware; meaning belongs to software.

// ****************************************************************
// Host-side token controller for one port
// ****************************************************************
module dpts_host (
    input  wire logic                        clk,
    input  wire logic                        resetn,
    input  wire logic                        ce,
    input  dpts_pkg::dpts_req_t              req,
    output logic                             req_ready,
    output dpts_pkg::dpts_rsp_t              rsp,
    output dpts_pkg::dpts_pins_t             pins,
    input  wire logic [`DPTS_DATA_W-1:0]     data_in
);
    import dpts_pkg::*;

    // ****************************************************************
    // Data pin synchroniser
    // ****************************************************************
    logic [`DPTS_DATA_W-1:0] din_meta_reg;
    logic [`DPTS_DATA_W-1:0] din_sync_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            din_meta_reg <= '1;
            din_sync_reg <= '1;
        end else if (ce) begin
            din_meta_reg <= data_in;
            din_sync_reg <= din_meta_reg;
        end
    end

    // ****************************************************************
    // Pin sequencer
    // ****************************************************************
    dpts_ctl_state_t st_reg;
    dpts_ctl_state_t st_next;
    logic            cyc_done;
    logic            cyc_flag;

    dpts_pin_cycle u_cycle (
        .clk          (clk),
        .resetn       (resetn),
        .ce           (ce),
        .go           (st_reg.cyc_go),
        .write        (st_reg.cyc_write),
        .idx          (st_reg.idx),
        .wbit         (st_reg.cyc_wbit),
        .data_in_sync (din_sync_reg),
        .pins         (pins),
        .done         (cyc_done),
        .rd_flag      (cyc_flag)
    );

    // ****************************************************************
    // Operation control
    // ****************************************************************
    // The flags drive nothing here; the result goes back to the requester
    // whose software decides what a token means. [R20]
    always_comb begin
        st_next           = st_reg;
        st_next.cyc_go    = 1'b0;
        st_next.rsp.valid = 1'b0;
        case (st_reg.state)
            DPTS_ST_IDLE: begin
                st_next.busy = 1'b0;
                if (req.valid) begin
                    st_next.busy     = 1'b1;
                    st_next.op       = req.op;
                    st_next.idx      = req.idx;
                    st_next.init_idx = 4'h0;
                    st_next.cyc_go   = 1'b1;
                    if (req.op == DPTS_OP_READ) begin
                        st_next.cyc_write = 1'b0;
                        st_next.state     = DPTS_ST_READ;
                    end else begin
                        st_next.cyc_write = 1'b1;
                        // Claim writes zero; release and init write one. [R2]
                        st_next.cyc_wbit  = (req.op == DPTS_OP_CLAIM) ?
                                            `DPTS_FLAG_CLAIM : `DPTS_FLAG_RELEASE;
                        if (req.op == DPTS_OP_INIT) begin
                            st_next.idx = 3'h0;                             // [R19]
                        end
                        st_next.state = DPTS_ST_WRITE;
                    end
                end
            end
            DPTS_ST_WRITE: begin
                if (cyc_done) begin
                    if (st_reg.op == DPTS_OP_CLAIM) begin
                        // Write then read back, never test then write. [R15]
                        st_next.cyc_write = 1'b0;
                        st_next.cyc_go    = 1'b1;
                        st_next.state     = DPTS_ST_READ;
                    end else if (st_reg.op == DPTS_OP_INIT &&
                                 st_reg.init_idx < 4'(`DPTS_TOKEN_COUNT - 1)) begin
                        // Latches start undefined, so free all eight. [R18] [R19] [R1]
                        st_next.init_idx = st_reg.init_idx + 4'h1;
                        st_next.idx      = st_reg.idx + 3'h1;
                        st_next.cyc_go   = 1'b1;
                    end else begin
                        st_next.state = DPTS_ST_DONE;
                    end
                end
            end
            DPTS_ST_READ: begin
                if (cyc_done) begin
                    st_next.state = DPTS_ST_DONE;
                end
            end
            DPTS_ST_DONE: begin
                st_next.rsp.valid = 1'b1;
                st_next.rsp.idx   = st_reg.idx;
                st_next.rsp.flag  = (st_reg.op == DPTS_OP_READ ||
                                     st_reg.op == DPTS_OP_CLAIM) ? cyc_flag : 1'b1;
                // Owned only if the read-back shows zero. [R15] [R6] [R11]
                st_next.rsp.granted = (st_reg.op == DPTS_OP_CLAIM) &&
                                      (cyc_flag == `DPTS_FLAG_CLAIM);
                // A failed claim leaves a request pending; the user must poll
                // with DPTS_OP_READ or withdraw with DPTS_OP_RELEASE. [R16] [R8]
                st_next.busy  = 1'b0;
                st_next.state = DPTS_ST_IDLE;
            end
            default: begin
                st_next.state = DPTS_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '{state: DPTS_ST_IDLE, op: DPTS_OP_READ, idx: 3'h0,
                        init_idx: 4'h0, cyc_go: 1'b0, cyc_write: 1'b0,
                        cyc_wbit: 1'b1, rsp: '{valid: 1'b0, granted: 1'b0,
                        flag: 1'b1, idx: 3'h0}, busy: 1'b0};
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign req_ready = ~st_reg.busy;
    assign rsp       = st_reg.rsp;
endmodule

//--- dpts_host_checker.sv
`timescale 1ns/1ps
// ****************************************************************
// Pin and response checks on one host port
// ****************************************************************
module dpts_host_checker (
    input  wire logic                        clk,
    input  wire logic                        resetn,
    input  wire logic                        ce,
    input  dpts_pkg::dpts_req_t              req,
    input  wire logic                        req_ready,
    input  dpts_pkg::dpts_rsp_t              rsp,
    input  dpts_pkg::dpts_pins_t             pins,
    input  wire logic [15:0]                 data_in
);
    import dpts_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire acc = ce && req.valid && req_ready;
    a_ram_off: assert property (pins.chip_enable_n)
        else $error("RAM enable driven low");
    a_addr_high_zero: assert property (!pins.token_bank_select_n
        |-> pins.addr[12:3] == 10'h0)
        else $error("upper address bits set in token access");
    a_write_bit_spread: assert property (!pins.read_write_n |-> pins.data_oe
        && (pins.data_out == 16'h0 || pins.data_out == 16'hffff))
        else $error("write data not one replicated bit");
    a_strobe_in_select: assert property ((!pins.output_enable_n || !pins.read_write_n)
        |-> !pins.token_bank_select_n)
        else $error("strobe outside token select");
    a_read_shape: assert property ($fell(pins.output_enable_n) |-> !pins.data_oe
        ##1 !pins.output_enable_n ##1 !pins.output_enable_n
        ##1 (pins.output_enable_n && pins.token_bank_select_n))
        else $error("read strobe shape wrong");
    a_select_gap: assert property ($rose(pins.token_bank_select_n)
        |=> pins.token_bank_select_n)
        else $error("select not released between accesses");
    a_claim_wr_rd: assert property (acc && req.op == DPTS_OP_CLAIM |-> ##[1:8]
        (!pins.read_write_n && !pins.data_out[0]) ##[1:12] !pins.output_enable_n)
        else $error("claim is not write zero then read");
    a_release_one: assert property (acc && req.op == DPTS_OP_RELEASE |-> ##[1:8]
        (!pins.read_write_n && pins.data_out[0]))
        else $error("release did not write one");
    a_grant_zero: assert property (rsp.valid && rsp.granted |-> !rsp.flag)
        else $error("grant without zero flag");
    a_rsp_pulse: assert property (rsp.valid |=> !rsp.valid && req_ready)
        else $error("response not a single pulse");
    c_grant: cover property (rsp.valid && rsp.granted);
    c_refused: cover property (rsp.valid && !rsp.granted && rsp.flag);
    c_init: cover property (acc && req.op == DPTS_OP_INIT);
endmodule

bind dpts_host dpts_host_checker dpts_host_checker_inst (.clk(clk), .resetn(resetn), .ce(ce),
    .req(req), .req_ready(req_ready), .rsp(rsp), .pins(pins), .data_in(data_in));

//--- dpts_dev_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Token device model with two ports
// ****************************************************************
module dpts_dev_model (
    input  dpts_pkg::dpts_pins_t lp,
    input  dpts_pkg::dpts_pins_t rp,
    output logic [15:0]          ld,
    output logic [15:0]          rd
);
    import dpts_pkg::*;
    // Owner per token: 0 free, 1 left, 2 right; nothing else is gated by it.
    logic [1:0] own [8];
    logic [1:0] pnd [8];
    logic       lq;
    logic       rq;
    // Power-up junk: held by the right with the left pending, so only a release
    // from both ports frees every token.
    initial begin
        for (int i = 0; i < 8; i++) begin
            own[i] = 2'h2;
            pnd[i] = 2'h1;
        end
        lq = 1'b0;
        rq = 1'b0;
    end
    task automatic wr(input logic [1:0] s, input dpts_pins_t p);
        logic [2:0] i;
        logic [1:0] o;
        i = p.addr[2:0];
        o = 2'h3 - s;
        if (!p.data_out[0]) begin
            if (own[i] == 2'h0) own[i] = s;
            else if (own[i] != s) pnd[i][s-2'h1] = 1'b1;
        end else begin
            pnd[i][s-2'h1] = 1'b0;
            if (own[i] == s) begin
                own[i] = pnd[i][o-2'h1] ? o : 2'h0;
                pnd[i][o-2'h1] = 1'b0;
            end
        end
    endtask
    wire lw = !lp.token_bank_select_n && !lp.read_write_n;
    wire rw = !rp.token_bank_select_n && !rp.read_write_n;
    wire lr = !lp.token_bank_select_n && !lp.output_enable_n && lp.read_write_n;
    wire rr = !rp.token_bank_select_n && !rp.output_enable_n && rp.read_write_n;
    always @(posedge lw) wr(2'h1, lp);
    always @(posedge rw) wr(2'h2, rp);
    // Frozen at the opening of a read so a write from the far port cannot change it.
    always @(posedge lr) lq = own[lp.addr[2:0]] != 2'h1;
    always @(posedge rr) rq = own[rp.addr[2:0]] != 2'h2;
    // Released data lines show the inverse of the last value, never a held copy.
    assign ld = lr ? {16{lq}} : {16{~lq}};
    assign rd = rr ? {16{rq}} : {16{~rq}};
endmodule

//--- test_dual_port_token_semaphores.sv
`timescale 1ns/1ps
// ****************************************************************
// Bench: host on the left port, bench tasks on the right port
// ****************************************************************
module test_dual_port_token_semaphores;
    import dpts_pkg::*;
    localparam dpts_pins_t IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 13'h0, 16'h0, 1'b0};
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    dpts_req_t   req = '0;
    dpts_pins_t  rp = IDLE;
    logic        req_ready;
    dpts_rsp_t   rsp;
    dpts_pins_t  hp;
    logic [15:0] hd;
    logic [15:0] rd;
    int          error_cnt = 0;
    int          checked = 0;

    always #20 clk = ~clk;

    dpts_host dpts_host_inst (.clk(clk), .resetn(resetn), .ce(1'b1), .req(req),
        .req_ready(req_ready), .rsp(rsp), .pins(hp), .data_in(hd));
    dpts_dev_model dpts_dev_model_inst (.lp(hp), .rp(rp), .ld(hd), .rd(rd));

    task automatic close_out;
        $display("checked %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic hop(input dpts_op_t op, input logic [2:0] ix, input logic ef, input logic eg);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 99) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk) req <= '{1'b1, op, ix};
        @(posedge clk) req.valid <= 1'b0;
        while (rsp.valid !== 1'b1 && n < 199) begin
            @(negedge clk);
            n++;
        end
        if (rsp.valid !== 1'b1) begin
            chk("host handshake", 16'h1, 16'h0);
            close_out();
        end
        chk("host flag", {15'h0, ef}, {15'h0, rsp.flag});
        chk("host grant", {15'h0, eg}, {15'h0, rsp.granted});
        chk("host index", {13'h0, ix}, {13'h0, rsp.idx});
    endtask
    task automatic rio(input logic [12:0] a, input logic w, input logic [15:0] d, input logic ef);
        @(posedge clk) rp <= '{1'b0, 1'b1, 1'b1, 1'b1, a, d, w};
        @(posedge clk) begin
            rp.output_enable_n <= w;
            rp.read_write_n <= !w;
        end
        @(posedge clk);
        @(negedge clk);
        if (!w) chk("right flag", {16{ef}}, rd);
        @(posedge clk) rp <= IDLE;
    endtask

    task automatic t_init;
        for (int i = 0; i < 8; i++) rio(13'(i), 1'b1, 16'hffff, 1'b0);
        hop(DPTS_OP_INIT, 3'h7, 1'b1, 1'b0);
        for (int i = 0; i < 8; i++) begin
            hop(DPTS_OP_READ, 3'(i), 1'b1, 1'b0);
            rio(13'(i), 1'b0, 16'h0, 1'b1);
        end
        $display("init test done");
    endtask
    task automatic t_own;
        hop(DPTS_OP_CLAIM, 3'h5, 1'b0, 1'b1);
        rio(13'h5, 1'b0, 16'h0, 1'b1);
        rio(13'h5, 1'b1, 16'h0, 1'b0);
        rio(13'h5, 1'b0, 16'h0, 1'b1);
        hop(DPTS_OP_READ, 3'h5, 1'b0, 1'b0);
        rio(13'h4, 1'b0, 16'h0, 1'b1);
        hop(DPTS_OP_RELEASE, 3'h5, 1'b1, 1'b0);
        hop(DPTS_OP_READ, 3'h5, 1'b1, 1'b0);
        rio(13'h5, 1'b0, 16'h0, 1'b0);
        rio(13'h5, 1'b1, 16'hffff, 1'b0);
        hop(DPTS_OP_READ, 3'h5, 1'b1, 1'b0);
        rio(13'h5, 1'b0, 16'h0, 1'b1);
        $display("ownership test done");
    endtask
    task automatic t_refuse;
        rio(13'h1a2, 1'b1, 16'hfffe, 1'b0);
        rio(13'h2, 1'b0, 16'h0, 1'b0);
        hop(DPTS_OP_CLAIM, 3'h2, 1'b1, 1'b0);
        hop(DPTS_OP_RELEASE, 3'h2, 1'b1, 1'b0);
        rio(13'h2, 1'b1, 16'h0001, 1'b0);
        hop(DPTS_OP_READ, 3'h2, 1'b1, 1'b0);
        rio(13'h2, 1'b0, 16'h0, 1'b1);
        $display("refusal test done");
    endtask
    task automatic t_latch;
        hop(DPTS_OP_CLAIM, 3'h6, 1'b0, 1'b1);
        rio(13'h6, 1'b1, 16'h0, 1'b0);
        // The right read opens while the left owns, so the live flag turns
        // to zero under it when ownership passes; the held value must not.
        @(posedge clk) rp <= '{1'b0, 1'b1, 1'b0, 1'b1, 13'h6, 16'h0, 1'b0};
        hop(DPTS_OP_RELEASE, 3'h6, 1'b1, 1'b0);
        @(negedge clk);
        chk("held flag", 16'hffff, rd);
        @(posedge clk) rp <= IDLE;
        rio(13'h6, 1'b0, 16'h0, 1'b0);
        rio(13'h6, 1'b1, 16'hffff, 1'b0);
        hop(DPTS_OP_READ, 3'h6, 1'b1, 1'b0);
        $display("latch test done");
    endtask
    task automatic t_tie;
        // The right write strobe lands two cycles before the host's, so the
        // right side is the earlier requester and must win.
        fork
            hop(DPTS_OP_CLAIM, 3'h0, 1'b1, 1'b0);
            rio(13'h0, 1'b1, 16'h0, 1'b0);
        join
        rio(13'h0, 1'b0, 16'h0, 1'b0);
        hop(DPTS_OP_RELEASE, 3'h0, 1'b1, 1'b0);
        rio(13'h0, 1'b1, 16'hffff, 1'b0);
        hop(DPTS_OP_READ, 3'h0, 1'b1, 1'b0);
        $display("tie test done");
    endtask

    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        t_init();
        t_own();
        t_refuse();
        t_latch();
        t_tie();
        close_out();
    end
endmodule
